// *** hdl/logic_branch_exec.sv ***
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "exec_defines.svh"
module logic_branch_exec
  import exec_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic [15:0]        prog_addr,
  input  wire logic [15:0]   prog_data,
  input  wire logic          next_long,
  output logic [4:0]         rd_addr,
  output logic [4:0]         rr_addr,
  input  wire logic [7:0]    rd_data,
  input  wire logic [7:0]    rr_data,
  output logic [4:0]         io_addr,
  input  wire logic [7:0]    io_data,
  input  wire logic [15:0]   z_ptr,
  output push_s              push,
  output logic               pop_req,
  input  wire logic [15:0]   pop_data,
  output wb_s                wb,
  output logic [7:0]         status_flags_register
);

  generate
    if (AW < 4) begin : g_aw_check
      $error("AW too small for the register map");
    end
  endgenerate

  logic        run;
  logic [15:0] pc;
  state_e      state;
  logic [1:0]  stall_cnt;

  // decode fields
  wire op_e       op      = op_e'(prog_data[`OP_HI:`OP_LO]);
  wire [1:0]      sub     = prog_data[`SUB_HI:`SUB_LO];
  wire [7:0]      k8      = prog_data[`IMM_K_HI:`IMM_K_LO];
  wire [6:0]      br_k    = prog_data[`BRK_HI:`BRK_LO];
  wire [2:0]      bitsel  = prog_data[`BIT_HI:`BIT_LO];
  wire [4:0]      imm_reg = {1'b1, prog_data[`IMM_REG_HI:`IMM_REG_LO]};
  wire            is_imm  = (prog_data[`OP_HI:`OP_LO] < 4'h4);

  wire go        = run && (state == ST_RUN);
  wire do_ori    = go && (op == OP_OR_IMM);
  wire do_cbr    = go && (op == OP_CLR_BITS);
  wire do_sbr    = go && (op == OP_SET_BITS);
  wire do_cpi    = go && (op == OP_CMP_IMM);
  wire do_tst    = go && (op == OP_REG) && (sub == REG_TEST);
  wire do_compare_skip_equal   = go && (op == OP_REG) && (sub == REG_COMPARE_SKIP_EQUAL);
  wire do_com    = go && (op == OP_REG) && (sub == REG_COM);
  wire do_neg    = go && (op == OP_REG) && (sub == REG_NEG);
  wire do_skip   = go && (op == OP_SKIP);
  wire do_brs    = go && (op == OP_BR_SET);
  wire do_brc    = go && (op == OP_BR_CLR);
  wire do_indirect_jump   = go && (op == OP_FLOW) && (sub == FL_INDIRECT_JUMP);
  wire do_indirect_call  = go && (op == OP_FLOW) && (sub == FL_INDIRECT_CALL);
  wire do_ret    = go && (op == OP_FLOW) && (sub == FL_RET);
  wire do_interrupt_return   = go && (op == OP_FLOW) && (sub == FL_INTERRUPT_RETURN);

  assign rd_addr   = is_imm ? imm_reg : prog_data[`RD_HI:`RD_LO];
  assign rr_addr   = prog_data[`RR_HI:`RR_LO];
  assign io_addr   = prog_data[`RD_HI:`RD_LO];
  assign prog_addr = pc;
  assign pop_req   = do_ret || do_interrupt_return;

  // register file writes land one edge late, so forward the pending value
  wire [7:0] rd_val = (wb.en && wb.addr == rd_addr) ? wb.data : rd_data;
  wire [7:0] rr_val = (wb.en && wb.addr == rr_addr) ? wb.data : rr_data;
  wire [7:0] sk_reg = (wb.en && wb.addr == io_addr) ? wb.data : rd_data;

  wire [7:0] f = status_flags_register;

  // skip conditions
  // index the selected bit instead of shifting, so no byte is cut down to one bit
  wire [7:0] sk_src = sub[1] ? io_data : sk_reg;
  wire       sk_bit = sk_src[bitsel];
  wire sk_hit  = sub[0] ? sk_bit : ~sk_bit;
  wire skip_go = (do_skip && sk_hit) || (do_compare_skip_equal && (rd_val == rr_val));

  // branch condition; S bit is evaluated live so stale software writes cannot mislead
  wire br_bit   = (bitsel == `FLAG_S) ? (f[`FLAG_N] ^ f[`FLAG_V]) : f[bitsel];
  wire br_taken = (do_brs && br_bit) || (do_brc && !br_bit);

  wire [15:0] pc_next1 = pc + 16'h0001;
  wire [15:0] pc_skip  = pc + (next_long ? `SKIP_LONG : `SKIP_SHORT);
  wire [15:0] pc_br    = pc + {{9{br_k[6]}}, br_k} + 16'h0001;

  // result and flag computation
  logic [7:0] res;
  logic       res_wr;
  logic       fl_upd;
  logic       c_new;
  logic       v_new;
  logic       h_new;
  logic       ch_upd;
  logic [8:0] diff;
  logic [4:0] diff_lo;

  always_comb begin
    res     = rd_val;
    res_wr  = 1'b0;
    fl_upd  = 1'b0;
    ch_upd  = 1'b0;
    c_new   = f[`FLAG_C];
    v_new   = 1'b0;
    h_new   = f[`FLAG_H];
    diff    = {1'b0, rd_val} - {1'b0, k8};
    diff_lo = {1'b0, rd_val[3:0]} - {1'b0, k8[3:0]};
    if (do_ori) begin
      res    = rd_val | k8;
      res_wr = 1'b1;
      fl_upd = 1'b1;
    end else if (do_cbr) begin
      res    = rd_val & (`ONES - k8);
      res_wr = 1'b1;
      fl_upd = 1'b1;
    end else if (do_sbr) begin
      res    = rd_val | k8;
      res_wr = 1'b1;
      fl_upd = 1'b1;
    end else if (do_tst) begin
      res    = rd_val & rd_val;
      fl_upd = 1'b1;
    end else if (do_cpi) begin
      res    = diff[7:0];
      fl_upd = 1'b1;
      ch_upd = 1'b1;
      c_new  = diff[8];
      h_new  = diff_lo[4];
      v_new  = (rd_val[7] & ~k8[7] & ~diff[7]) | (~rd_val[7] & k8[7] & diff[7]);
    end else if (do_com) begin
      res    = `ONES - rd_val;
      res_wr = 1'b1;
      fl_upd = 1'b1;
      ch_upd = 1'b1;
      c_new  = 1'b1;
    end else if (do_neg) begin
      res    = 8'h00 - rd_val;
      res_wr = 1'b1;
      fl_upd = 1'b1;
      ch_upd = 1'b1;
      c_new  = (res != 8'h00);
      v_new  = (res == `MSB_ONLY);
      h_new  = res[3] | rd_val[3];
    end
  end

  wire [7:0] flags_alu = {f[`FLAG_I], f[`FLAG_T],
                          (ch_upd ? h_new : f[`FLAG_H]),
                          res[7] ^ v_new, v_new, res[7], (res == 8'h00),
                          (ch_upd ? c_new : f[`FLAG_C])};

  // software writes to flags are overridden by a flag-updating instruction or interrupt_return in the same cycle
  wire        apb_acc   = psel && penable;
  wire        apb_setup = psel && !penable;
  wire        hit_ctrl  = (paddr == AW'(`OFF_CTRL));
  wire        hit_flags = (paddr == AW'(`OFF_FLAGS));
  wire        hit_pc    = (paddr == AW'(`OFF_PC));
  wire        hit_any   = hit_ctrl || hit_flags || hit_pc;
  wire        wr_ctrl   = apb_acc && pwrite && hit_ctrl;
  wire        wr_flags  = apb_acc && pwrite && hit_flags;
  wire        wr_pc     = apb_acc && pwrite && hit_pc && !run;

  wire [7:0] next_flags = fl_upd  ? flags_alu :
                          do_interrupt_return ? (f | (8'h01 << `FLAG_I)) :
                          wr_flags ? pwdata[7:0] : f;

  // program counter and stall length
  logic [15:0] next_pc;
  logic [1:0]  next_stall;

  always_comb begin
    next_pc    = pc;
    next_stall = 2'd0;
    if (wr_pc) begin
      next_pc = pwdata[15:0];
    end else if (do_indirect_jump) begin
      next_pc    = z_ptr;
      next_stall = 2'(`CYC_INDIRECT_JUMP - 1);
    end else if (do_indirect_call) begin
      next_pc    = z_ptr;
      next_stall = 2'(`CYC_INDIRECT_CALL - 1);
    end else if (do_ret || do_interrupt_return) begin
      next_pc    = pop_data;
      next_stall = 2'(`CYC_RET - 1);
    end else if (skip_go) begin
      next_pc    = pc_skip;
      next_stall = 2'(`CYC_TAKEN - 1);
    end else if (br_taken) begin
      next_pc    = pc_br;
      next_stall = 2'(`CYC_TAKEN - 1);
    end else if (go) begin
      next_pc = pc_next1;
    end
  end

  wire    stall_done = (stall_cnt == 2'd1);
  state_e next_state;
  always_comb begin
    unique case (state)
      ST_RUN:   next_state = (next_stall != 2'd0) ? ST_STALL : ST_RUN;
      ST_STALL: next_state = stall_done ? ST_RUN : ST_STALL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_RUN;
      stall_cnt <= 2'd0;
      pc        <= `RST_PC;
      status_flags_register <= `RST_FLAGS;
    end else begin
      state     <= next_state;
      stall_cnt <= (state == ST_RUN) ? next_stall : stall_cnt - 2'd1;
      pc        <= next_pc;
      status_flags_register <= next_flags;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb   <= '0;
      push <= '0;
    end else begin
      wb   <= '{en: res_wr, addr: rd_addr, data: res};
      push <= '{valid: do_indirect_call, data: pc_next1};
    end
  end

  // APB slave: zero wait states, read data captured in setup phase
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !hit_any;

  wire [31:0] rd_mux = hit_ctrl  ? {31'h0, run} :
                       hit_flags ? {24'h0, f} :
                       hit_pc    ? {16'h0, pc} : 32'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run    <= `RST_CTRL;
      prdata <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        run <= pwdata[`CTRL_RUN];
      end
      if (apb_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // checks
  a_ori_result: assert property (@(posedge core_clk) disable iff (!rstn)
    do_ori |=> wb.en && wb.data == ($past(rd_val) | $past(k8)) && state == ST_RUN)
    else $error("or_immediate result wrong");

  a_cbr_result: assert property (@(posedge core_clk) disable iff (!rstn)
    do_cbr |=> wb.en && wb.data == ($past(rd_val) & ~$past(k8)) && !f[`FLAG_V])
    else $error("clear_bits_masked result wrong");

  a_sbr_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    do_sbr |=> ((wb.data & $past(k8)) == $past(k8)) && state == ST_RUN)
    else $error("set_bits_masked left a bit low");

  a_tst_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    do_tst |=> !wb.en && f[`FLAG_Z] == ($past(rd_val) == 8'h00) && f[`FLAG_N] == $past(rd_val[7]))
    else $error("test_zero_minus flags wrong");

  a_indirect_jump_timing: assert property (@(posedge core_clk) disable iff (!rstn)
    do_indirect_jump |=> pc == $past(z_ptr) && f == $past(f) && !go ##1 state == ST_RUN)
    else $error("indirect_jump timing wrong");

  a_indirect_call_push: assert property (@(posedge core_clk) disable iff (!rstn)
    do_indirect_call |=> push.valid && push.data == $past(pc) + 16'h0001 && pc == $past(z_ptr)
                 ##1 state == ST_STALL ##1 state == ST_RUN)
    else $error("indirect_call push or timing wrong");

  a_skip_pc: assert property (@(posedge core_clk) disable iff (!rstn)
    (do_compare_skip_equal && rd_val == rr_val && !wr_pc) |=>
      pc == $past(pc) + ($past(next_long) ? 16'h0003 : 16'h0002) ##1 state == ST_RUN)
    else $error("compare_skip_equal pc wrong");

  a_cpi_carry: assert property (@(posedge core_clk) disable iff (!rstn)
    do_cpi |=> !wb.en && f[`FLAG_C] == ($past(rd_val) < $past(k8)) && f[`FLAG_Z] == ($past(rd_val) == $past(k8)))
    else $error("compare_immediate flags wrong");

  a_bit_skip: assert property (@(posedge core_clk) disable iff (!rstn)
    (do_skip && !wr_pc) |=> (pc == $past(pc) + 16'h0001) == !$past(sk_hit) && f == $past(f))
    else $error("bit skip decision wrong");

  a_branch_pc: assert property (@(posedge core_clk) disable iff (!rstn)
    (br_taken && !wr_pc) |=> pc == $past(pc_br) && state == ST_STALL ##1 state == ST_RUN)
    else $error("branch target or timing wrong");

  a_signed_ge: assert property (@(posedge core_clk) disable iff (!rstn)
    (do_brc && bitsel == `FLAG_S) |-> br_taken == !(f[`FLAG_N] ^ f[`FLAG_V]))
    else $error("signed branch condition wrong");

  a_interrupt_return_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    do_interrupt_return |=> f[`FLAG_I] && pc == $past(pop_data) ##1 !go ##1 !go ##1 state == ST_RUN)
    else $error("interrupt_return wrong");

  a_neg_result: assert property (@(posedge core_clk) disable iff (!rstn)
    do_neg |=> wb.data == 8'h00 - $past(rd_val) && f[`FLAG_C] == ($past(rd_val) != 8'h00))
    else $error("twos_negate wrong");

endmodule

// *** pkg/exec_defines.svh ***
// Overview of operation
// - or_immediate ORs constant in, sets Z N V, 1 cycle
// - clear_bits_masked ANDs with inverted mask, sets Z N V
// - set_bits_masked forces masked bits high, 1 cycle
// - test_zero_minus keeps register, sets Z N V
// - indirect_jump loads PC from Z, 2 cycles
// - indirect_call pushes return, jumps to Z, 3 cycles
// - compare_skip_equal skips next when registers equal
// - compare_immediate subtracts constant, sets Z N V C H
// - skip_reg_bit_clear skips when register bit zero
// - skip_reg_bit_set skips when register bit one
// - skip_io_bit_clear skips when I/O bit zero
// - skip_io_bit_set skips when I/O bit one
// - branch_flag_set jumps PC+k+1 when flag one
// - branch_flag_clear jumps when selected flag zero
// - branch_signed_ge taken when N xor V zero
// - branch_signed_lt taken when N xor V one
// - half-carry branches follow H flag
// - overflow branches follow V flag
// - unsigned ge and carry-clear taken when C zero
// - T-flag branches follow T flag
// - interrupt-state branches follow I flag
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

`define OFF_CTRL      12'h000
`define OFF_FLAGS     12'h004
`define OFF_PC        12'h008

`define CTRL_RUN      0
`define RST_CTRL      1'b0
`define RST_FLAGS     8'h00
`define RST_PC        16'h0000

`define FLAG_C        3'h0
`define FLAG_Z        3'h1
`define FLAG_N        3'h2
`define FLAG_V        3'h3
`define FLAG_S        3'h4
`define FLAG_H        3'h5
`define FLAG_T        3'h6
`define FLAG_I        3'h7

`define CYC_INDIRECT_JUMP      2
`define CYC_INDIRECT_CALL     3
`define CYC_RET       4
`define CYC_TAKEN     2

`define OP_HI         15
`define OP_LO         12
`define SUB_HI        11
`define SUB_LO        10
`define IMM_REG_HI    11
`define IMM_REG_LO    8
`define IMM_K_HI      7
`define IMM_K_LO      0
`define RD_HI         9
`define RD_LO         5
`define RR_HI         4
`define RR_LO         0
`define BIT_HI        2
`define BIT_LO        0
`define BRK_HI        9
`define BRK_LO        3

`define SKIP_SHORT    16'h0002
`define SKIP_LONG     16'h0003
`define ONES          8'hff
`define MSB_ONLY      8'h80

`endif

// *** pkg/exec_pkg.sv ***
package exec_pkg;

  typedef enum logic [3:0] {
    OP_OR_IMM   = 4'b0000,
    OP_CLR_BITS = 4'b0001,
    OP_SET_BITS = 4'b0010,
    OP_CMP_IMM  = 4'b0011,
    OP_REG      = 4'b0100,
    OP_SKIP     = 4'b0101,
    OP_BR_SET   = 4'b0110,
    OP_BR_CLR   = 4'b0111,
    OP_FLOW     = 4'b1000
  } op_e;

  typedef enum logic [1:0] {
    REG_TEST = 2'b00,
    REG_COMPARE_SKIP_EQUAL = 2'b01,
    REG_COM  = 2'b10,
    REG_NEG  = 2'b11
  } reg_sub_e;

  typedef enum logic [1:0] {
    SK_REG_CLR = 2'b00,
    SK_REG_SET = 2'b01,
    SK_IO_CLR  = 2'b10,
    SK_IO_SET  = 2'b11
  } skip_sub_e;

  typedef enum logic [1:0] {
    FL_INDIRECT_JUMP  = 2'b00,
    FL_INDIRECT_CALL = 2'b01,
    FL_RET   = 2'b10,
    FL_INTERRUPT_RETURN  = 2'b11
  } flow_sub_e;

  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_STALL = 1'b1
  } state_e;

  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } wb_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } push_s;

endpackage

// *** verification/prog_regfile_model.sv ***
`timescale 1ns/100ps
module prog_regfile_model
  import exec_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [15:0] prog_addr,
  output logic [15:0]      prog_data,
  output logic             next_long,
  input  wire logic [4:0]  rd_addr,
  input  wire logic [4:0]  rr_addr,
  output logic [7:0]       rd_data,
  output logic [7:0]       rr_data,
  input  wire logic [4:0]  io_addr,
  output logic [7:0]       io_data,
  input  wire push_s       push,
  input  wire logic        pop_req,
  output logic [15:0]      pop_data,
  input  wire wb_s         wb
);
  logic [15:0] mem [256];
  logic [7:0]  regs [32];
  logic [7:0]  io [32];
  logic [15:0] top;
  logic        long_next;

  // small memory, so branch targets wrap onto it
  assign prog_data = mem[prog_addr[7:0]];
  assign next_long = long_next;
  assign rd_data   = regs[rd_addr];
  assign rr_data   = regs[rr_addr];
  assign io_data   = io[io_addr];
  // stack word only valid while popped; garbage otherwise
  assign pop_data  = pop_req ? top : ~top;

  always @(posedge core_clk) begin
    if (wb.en) begin
      regs[wb.addr] <= wb.data;
    end
    if (push.valid) begin
      top <= push.data;
    end
  end
endmodule

// *** verification/test_logic_and_branch_execution.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"
module test_logic_and_branch_execution;
  import exec_pkg::*;
  logic        core_clk = 0;
  logic        rstn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic [15:0] prog_addr;
  logic [15:0] prog_data;
  logic [15:0] pop_data;
  logic [15:0] z_ptr = '0;
  logic        next_long;
  logic        pop_req;
  logic [4:0]  rd_addr;
  logic [4:0]  rr_addr;
  logic [4:0]  io_addr;
  logic [7:0]  rd_data;
  logic [7:0]  rr_data;
  logic [7:0]  io_data;
  logic [7:0]  status_flags_register;
  push_s       push;
  wb_s         wb;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [7:0]  ftab [4] = '{8'h00, 8'hff, 8'h04, 8'h08};

  always #10 core_clk = ~core_clk;

  logic_branch_exec #(.AW(12)) dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_data(prog_data), .next_long(next_long), .rd_addr(rd_addr), .rr_addr(rr_addr),
    .rd_data(rd_data), .rr_data(rr_data), .io_addr(io_addr), .io_data(io_data), .z_ptr(z_ptr), .push(push),
    .pop_req(pop_req), .pop_data(pop_data), .wb(wb), .status_flags_register(status_flags_register));

  prog_regfile_model model (.core_clk(core_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .next_long(next_long), .rd_addr(rd_addr), .rr_addr(rr_addr), .rd_data(rd_data), .rr_data(rr_data),
    .io_addr(io_addr), .io_data(io_data), .push(push), .pop_req(pop_req), .pop_data(pop_data), .wb(wb));

  task summarize;
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      summarize();
    end
  end

  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, "apb answer missing");
  endtask

  function automatic logic [7:0] lgc(input logic [7:0] f, input logic [7:0] r);
    lgc = f;
    lgc[1] = (r == 8'h00);
    lgc[2] = r[7];
    lgc[3] = 1'b0;
  endfunction

  function automatic logic [7:0] sbf(input logic [7:0] f, input logic [7:0] x, input logic [7:0] y);
    logic [7:0] d;
    d = x - y;
    sbf = f;
    sbf[0] = x < y;
    sbf[1] = (d == 8'h00);
    sbf[2] = d[7];
    sbf[3] = (x[7] & ~y[7] & ~d[7]) | (~x[7] & y[7] & d[7]);
    sbf[5] = x[3:0] < y[3:0];
  endfunction

  task run_case(input logic [15:0] ins, input logic [7:0] f);
    logic [3:0]  op;
    logic [1:0]  s2;
    logic [7:0]  r, q, res, nf, fv;
    logic [4:0]  wr;
    logic [15:0] tgt, zv;
    logic        we, skp, bitv;
    int          c;
    op = ins[15:12];
    s2 = ins[11:10];
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_PC, 32'h0);
    apb(1'b1, `OFF_FLAGS, {24'h0, f});
    zv = 16'($urandom) | 16'h0010;
    z_ptr <= zv;
    model.top = 16'($urandom) | 16'h0010;
    model.long_next = 1'($urandom);
    model.mem[0] = ins;
    if (op == 4'h4 && $urandom % 2) model.regs[ins[4:0]] = model.regs[ins[9:5]];
    wr = (op < 4'h4) ? {1'b1, ins[11:8]} : ins[9:5];
    r = model.regs[wr];
    q = model.regs[ins[4:0]];
    tgt = 16'h1;
    c = 1;
    nf = f;
    we = 0;
    skp = 0;
    res = r;
    case (op)
      4'h0, 4'h2: begin res = r | ins[7:0]; we = 1; nf = lgc(f, res); end
      4'h1: begin res = r & ~ins[7:0]; we = 1; nf = lgc(f, res); end
      4'h3: nf = sbf(f, r, ins[7:0]);
      4'h4: case (s2)
        2'd0: nf = lgc(f, r);
        2'd1: skp = (r == q);
        2'd2: begin res = ~r; we = 1; nf = lgc(f, res); nf[0] = 1'b1; end
        default: begin res = 8'h00 - r; we = 1; nf = sbf(f, 8'h00, r); end
      endcase
      4'h5: begin
        bitv = s2[1] ? model.io[ins[9:5]][ins[2:0]] : r[ins[2:0]];
        skp = (bitv == s2[0]);
      end
      4'h6, 4'h7: begin
        fv = f;
        fv[4] = f[2] ^ f[3];
        if (fv[ins[2:0]] == (op == 4'h6)) begin
          tgt = {{9{ins[9]}}, ins[9:3]} + 16'h1;
          c = 2;
        end
      end
      4'h8: begin
        tgt = s2[1] ? model.top : zv;
        c = s2[1] ? 4 : (s2[0] ? 3 : 2);
        if (s2 == 2'd3) nf[7] = 1'b1;
      end
      default: ;
    endcase
    if (skp) begin
      tgt = model.long_next ? 16'h3 : 16'h2;
      c = 2;
    end
    apb(1'b1, `OFF_CTRL, 32'h1);
    for (int i = 1; i <= c + 1; i++) begin
      @(posedge core_clk);
      @(negedge core_clk);
      if (i == 1) model.mem[0] = 16'hf000;
      if (i == 1 || i == c) chk(prog_addr === tgt, "target or stall");
      if (i == c + 1) chk(prog_addr === tgt + 16'h1, "cycle count");
    end
    chk((status_flags_register & 8'hef) === (nf & 8'hef), "flags");
    chk(model.regs[wr] === (we ? res : r), "register result");
    if (op == 4'h8 && s2 == 2'd1) chk(model.top === 16'h0001, "return address");
  endtask

  initial begin
    void'($urandom(32'h2b9eeba4));
    for (int i = 0; i < 256; i++) model.mem[i] = 16'hf000;
    for (int i = 0; i < 32; i++) begin
      model.regs[i] = 8'($urandom);
      model.io[i] = 8'($urandom);
    end
    model.top = '0;
    model.long_next = 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, `OFF_FLAGS, 32'h0);
    chk(rdv === 32'h0 && slv === 1'b0, "flags reset value");
    apb(1'b0, `OFF_PC, 32'h0);
    chk(rdv === 32'h0 && slv === 1'b0, "pc reset value");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rdv === 32'h0 && slv === 1'b1, "unmapped read");
    // every flag index, both branch senses, flag patterns incl. N^V cases
    for (int o = 6; o < 8; o++)
      for (int s = 0; s < 8; s++)
        for (int j = 0; j < 4; j++) run_case({4'(o), 2'b00, 7'h7a, 3'(s)}, ftab[j]);
    for (int s = 0; s < 4; s++) run_case({4'h8, 2'(s), 10'h0}, 8'h00);
    repeat (140) run_case({4'($urandom % 9), 12'($urandom)}, 8'($urandom));
    summarize();
  end
endmodule
